// ### rtl/dpdiag_top.sv
/*
 * DP slave diagnostic block: checks parameter and configuration telegrams,
 * keeps station status one, and streams the diagnostic response byte by byte.
 * Assumes the telegram decoder delivers one-cycle records, the transmitter
 * drains the response with a ready handshake, and software uses AXI4-Lite.
 */
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dpdiag_regs.svh"

module dpdiag_top #(
  parameter logic [15:0] IDENT_RST  = 16'h5a5a, // Arbitrary value
  parameter bit          SYNC_SUP   = 1'b0,
  parameter bit          FREEZE_SUP = 1'b0,
  parameter int          EXT_WORDS  = 59
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire dpdiag_pkg::dpd_axil_req_t axi_req,
  output var  dpdiag_pkg::dpd_axil_rsp_t axi_rsp,
  input  wire dpdiag_pkg::dpd_prm_t   prm,
  input  wire dpdiag_pkg::dpd_cfg_t   cfg,
  input  wire logic                   diag_req,
  input  wire logic                   diag_ready,
  output var  dpdiag_pkg::dpd_diag_t  diag,
  output logic                        diag_busy
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (EXT_WORDS < 1 || EXT_WORDS * 4 + 6 > 244)
  begin : g_bad_ext
    $error("EXT_WORDS does not fit a 244 byte response");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  dpdiag_pkg::dpd_axil_rsp_t rsp_q;
  dpdiag_pkg::dpd_diag_t     diag_q;
  dpdiag_pkg::dpd_state_t    state_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [15:0] ident_q;
  logic [31:0] cfg_exp_q;
  logic [7:0]  ext_len_q;
  logic [7:0]  st2_q;
  logic [7:0]  st3_q;
  logic [31:0] ext_mem [EXT_WORDS];
  logic        prm_ok_q;
  logic        cfg_ok_q;
  logic        prm_fault_q;
  logic        not_supp_q;
  logic        cfg_fault_q;
  logic [7:0]  master_q;
  logic [7:0]  idx_q;
  logic [7:0]  len_q;

  // ****************************************************************
  // Status and header bytes
  // ****************************************************************
  wire logic        prm_short = prm.len < `DPD_PRM_MIN_LEN;
  wire logic        prm_bad   = prm.bad_value | prm_short
                              | (prm.ident != ident_q);
  wire logic        prm_unsup = (prm.sync_en & ~SYNC_SUP)
                              | (prm.freeze_en & ~FREEZE_SUP);
  wire logic        ready     = prm_ok_q & cfg_ok_q;
  wire logic        ext_diag  = ext_len_q != 8'h00;
  wire logic [7:0]  st1 = {1'b0, prm_fault_q, 1'b0, not_supp_q,
                           ext_diag, cfg_fault_q, ~ready, 1'b0};
  wire logic [7:0]  master_out = ready ? master_q : `DPD_NO_MASTER;
  wire logic [7:0]  resp_len = `DPD_HDR_LEN + ext_len_q;

  // ****************************************************************
  // Byte selection for the response stream
  // ****************************************************************
  wire logic [7:0]  ext_idx  = idx_q - `DPD_HDR_LEN;
  wire logic [31:0] ext_word = ext_mem[ext_idx[7:2]];
  wire logic [7:0]  ext_byte = ext_word[{ext_idx[1:0], 3'b000} +: 8];
  logic [7:0] tx_byte;
  always_comb
  begin
    case (idx_q)
      8'h00:   tx_byte = st1;
      8'h01:   tx_byte = st2_q;
      8'h02:   tx_byte = st3_q;
      8'h03:   tx_byte = master_out;
      8'h04:   tx_byte = ident_q[15:8];
      8'h05:   tx_byte = ident_q[7:0];
      default: tx_byte = ext_byte;
    endcase
  end

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic [31:0] wmask;
  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    assign wmask[b*8 +: 8] = {8{wstrb_q[b]}};
  end

  wire logic        do_wr    = ~rsp_q.awready & ~rsp_q.wready & ~rsp_q.bvalid;
  wire logic        wr_ext   = awaddr_q >= `DPD_OFF_EXT_BASE
                             && awaddr_q[11:2] < 10'(EXT_WORDS + 64);
  wire logic [9:0]  wr_word  = awaddr_q[11:2] - 10'h040;
  wire logic        wr_hit   = wr_ext || awaddr_q[11:4] == 8'h00;
  wire logic        rd_ext   = axi_req.araddr >= `DPD_OFF_EXT_BASE
                             && axi_req.araddr[11:2] < 10'(EXT_WORDS + 64);
  wire logic [9:0]  rd_word  = axi_req.araddr[11:2] - 10'h040;
  wire logic        ar_take  = axi_req.arvalid & rsp_q.arready;
  wire logic [7:0]  len_clip = ext_len_q > 8'(EXT_WORDS * 4) ? 8'(EXT_WORDS * 4)
                             : ext_len_q;
  logic [31:0] rd_data;
  logic        rd_hit;
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    if (rd_ext)
      rd_data = ext_mem[rd_word[5:0]];
    else if (axi_req.araddr[11:8] != 4'h0)
      rd_hit = 1'b0;
    else
      case (axi_req.araddr[7:0])
        `DPD_OFF_IDENT:   rd_data = {16'h0000, ident_q};
        `DPD_OFF_CFG:     rd_data = cfg_exp_q;
        `DPD_OFF_DIAGCTL: rd_data = {8'h00, st3_q, st2_q, ext_len_q};
        `DPD_OFF_STATUS:  rd_data = {7'h00, diag_busy, resp_len, master_out, st1};
        default:          rd_hit  = 1'b0;
      endcase
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rsp_q    <= '0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      rsp_q.awready <= 1'b1;
      rsp_q.wready  <= 1'b1;
      rsp_q.arready <= 1'b1;
    end
    else
    begin
      if (axi_req.awvalid && rsp_q.awready)
      begin
        awaddr_q      <= axi_req.awaddr;
        rsp_q.awready <= 1'b0;
      end
      if (axi_req.wvalid && rsp_q.wready)
      begin
        wdata_q      <= axi_req.wdata;
        wstrb_q      <= axi_req.wstrb;
        rsp_q.wready <= 1'b0;
      end
      if (do_wr)
      begin
        rsp_q.bvalid <= 1'b1;
        rsp_q.bresp  <= wr_hit ? `DPD_RESP_OKAY : `DPD_RESP_DECERR;
      end
      if (rsp_q.bvalid && axi_req.bready)
      begin
        rsp_q.bvalid  <= 1'b0;
        rsp_q.awready <= 1'b1;
        rsp_q.wready  <= 1'b1;
      end
      if (ar_take)
      begin
        rsp_q.arready <= 1'b0;
        rsp_q.rvalid  <= 1'b1;
        rsp_q.rdata   <= rd_data;
        rsp_q.rresp   <= rd_hit ? `DPD_RESP_OKAY : `DPD_RESP_DECERR;
      end
      if (rsp_q.rvalid && axi_req.rready)
      begin
        rsp_q.rvalid  <= 1'b0;
        rsp_q.arready <= 1'b1;
      end
    end
  end

  // Extended data has no reset; software fills it before raising the length
  always_ff @(posedge aclk)
  begin
    if (do_wr && wr_ext)
      ext_mem[wr_word[5:0]] <= (ext_mem[wr_word[5:0]] & ~wmask) | (wdata_q & wmask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ident_q   <= IDENT_RST;
      cfg_exp_q <= `DPD_RST_CFG;
      ext_len_q <= 8'h00;
      st2_q     <= 8'h00;
      st3_q     <= 8'h00;
    end
    else if (do_wr && !wr_ext)
    begin
      case (awaddr_q[7:0])
        `DPD_OFF_IDENT:
          ident_q <= (ident_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
        `DPD_OFF_CFG:
          cfg_exp_q <= (cfg_exp_q & ~wmask) | (wdata_q & wmask);
        `DPD_OFF_DIAGCTL:
        begin
          if (wstrb_q[0])
            ext_len_q <= wdata_q[7:0];
          if (wstrb_q[1])
            st2_q <= wdata_q[15:8];
          if (wstrb_q[2])
            st3_q <= wdata_q[23:16];
        end
        default: ;
      endcase
    end
    else if (ext_len_q != len_clip)
      ext_len_q <= len_clip;
  end

  // ****************************************************************
  // Telegram checks
  // ****************************************************************
  // A new parameter telegram restarts start-up, so configuration is redone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prm_ok_q    <= 1'b0;
      cfg_ok_q    <= 1'b0;
      prm_fault_q <= 1'b0;
      not_supp_q  <= 1'b0;
      cfg_fault_q <= 1'b0;
      master_q    <= `DPD_NO_MASTER;
    end
    else if (prm.valid)
    begin
      prm_fault_q <= prm_bad;
      not_supp_q  <= prm_unsup;
      prm_ok_q    <= ~prm_bad & ~prm_unsup;
      cfg_ok_q    <= 1'b0;
      cfg_fault_q <= 1'b0;
      master_q    <= prm.master;
    end
    else if (cfg.valid)
    begin
      cfg_fault_q <= cfg.cfg != cfg_exp_q;
      cfg_ok_q    <= prm_ok_q & (cfg.cfg == cfg_exp_q);
    end
  end

  // ****************************************************************
  // Response stream
  // ****************************************************************
  // Status is sampled byte by byte, so a telegram mid-response shows at once
  wire logic load = !diag_q.valid || diag_ready;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q   <= dpdiag_pkg::DPD_IDLE;
      diag_q    <= '0;
      idx_q     <= 8'h00;
      len_q     <= `DPD_HDR_LEN;
      diag_busy <= 1'b0;
    end
    else
    begin
      case (state_q)
        dpdiag_pkg::DPD_IDLE:
        begin
          if (diag_req)
          begin
            state_q   <= dpdiag_pkg::DPD_SEND;
            idx_q     <= 8'h00;
            len_q     <= resp_len;
            diag_busy <= 1'b1;
          end
        end
        dpdiag_pkg::DPD_SEND:
        begin
          if (load)
          begin
            if (idx_q < len_q)
            begin
              diag_q.valid <= 1'b1;
              diag_q.data  <= tx_byte;
              diag_q.last  <= idx_q == len_q - 8'h01;
              idx_q        <= idx_q + 8'h01;
            end
            else
            begin
              diag_q    <= '0;
              state_q   <= dpdiag_pkg::DPD_IDLE;
              diag_busy <= 1'b0;
            end
          end
        end
        default: state_q <= dpdiag_pkg::DPD_IDLE;
      endcase
    end
  end

  assign axi_rsp = rsp_q;
  assign diag    = diag_q;

endmodule : dpdiag_top
`default_nettype wire

// ### rtl/dpdiag_regs.svh
/*
 * Register offsets, field positions, reset values and limits of the DP slave
 * diagnostic block. Assumes a 32-bit AXI4-Lite register bus, byte addresses.
 */
// Behaviour
// - Diagnostic response length is 6 to 244 bytes.
// - Header order: status one, two, three, master address, ident number.
// - Master field reads 255 until parameterised and configured without error.
// - Every parameter telegram is checked whole; faults set status-one bit 6.
// - Ident number mismatch in the parameter telegram counts as parameter fault.
// - Unsupported requested function, such as sync or freeze, sets bit 4.
// - Bit 3 is set while extended diagnostic bytes follow the header.
// - Configuration differing from the internal one sets status-one bit 2.
// - Bit 1 is set while the slave is not ready for data exchange.
`ifndef DPDIAG_REGS_SVH
`define DPDIAG_REGS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define DPD_OFF_IDENT     8'h00
`define DPD_OFF_CFG       8'h04
`define DPD_OFF_DIAGCTL   8'h08
`define DPD_OFF_STATUS    8'h0c
`define DPD_OFF_EXT_BASE  12'h100

// ****************************************************************
// Fields and values
// ****************************************************************
`define DPD_ST1_LOCK      7
`define DPD_ST1_PRM_FAULT 6
`define DPD_ST1_BAD_RESP  5
`define DPD_ST1_NOT_SUPP  4
`define DPD_ST1_EXT_DIAG  3
`define DPD_ST1_CFG_FAULT 2
`define DPD_ST1_NOT_READY 1
`define DPD_ST1_NO_STAT   0
`define DPD_HDR_LEN       8'h06
`define DPD_MAX_LEN       8'hf4
`define DPD_NO_MASTER     8'hff
`define DPD_PRM_MIN_LEN   8'h07
`define DPD_RST_CFG       32'h0000_0000
`define DPD_RESP_OKAY     2'h0
`define DPD_RESP_DECERR   2'h3

`endif

// ### rtl/dpdiag_pkg.sv
/*
 * Types of the DP slave diagnostic block: bus carriers and telegram records.
 * Assumes the constants header is included by the modules that need offsets.
 */
package dpdiag_pkg;

  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } dpd_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dpd_axil_rsp_t;

  // One checked parameter telegram, presented for a single cycle
  typedef struct packed {
    logic        valid;
    logic [7:0]  master;
    logic [15:0] ident;
    logic        sync_en;
    logic        freeze_en;
    logic [7:0]  len;
    logic        bad_value;
  } dpd_prm_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] cfg;
  } dpd_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } dpd_diag_t;

  typedef enum logic [0:0] {
    DPD_IDLE = 1'b0,
    DPD_SEND = 1'b1
  } dpd_state_t;

endpackage : dpdiag_pkg

// ### bench/dpd_diag_asserts.sv
/*
 * Port assertions for the DP slave diagnostic block.
 * Assumes it is bound onto dpdiag_top and that all of it runs on aclk.
 */
`timescale 1ns/1ps
`default_nettype none

module dpd_diag_asserts (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire dpdiag_pkg::dpd_axil_req_t axi_req,
  input wire dpdiag_pkg::dpd_axil_rsp_t axi_rsp,
  input wire dpdiag_pkg::dpd_prm_t      prm,
  input wire dpdiag_pkg::dpd_cfg_t      cfg,
  input wire logic                      diag_req,
  input wire logic                      diag_ready,
  input wire dpdiag_pkg::dpd_diag_t     diag,
  input wire logic                      diag_busy
);
  logic [7:0] idx_q;
  logic [7:0] st1_q;
  wire        take = diag.valid && diag_ready;
  wire        first = diag.valid && idx_q == 8'h00;

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Byte position inside the current response
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !diag_busy) idx_q <= 8'h00;
    else if (take) idx_q <= idx_q + 8'h01;
    if (first) st1_q <= diag.data;
  end

  busy_start_a: assert property (diag_req && !diag_busy |=> diag_busy ##1 diag.valid)
    else $error("response did not start on time");
  byte_hold_a: assert property (diag.valid && !diag_ready |=>
    diag.valid && $stable(diag.data) && $stable(diag.last))
    else $error("stalled byte changed");
  hdr_len_a: assert property (diag.valid && diag.last |-> idx_q >= 8'h05 && idx_q <= 8'hf3)
    else $error("response length out of range");
  stream_end_a: assert property (take && diag.last |=> !diag.valid && !diag_busy)
    else $error("stream did not end after last byte");
  master_none_a: assert property (diag.valid && idx_q == 8'h03 && st1_q[1] |-> diag.data == 8'hff)
    else $error("master field not 255 while not ready");
  slave_bits_a: assert property (first |-> diag.data[7] == 1'b0 &&
    diag.data[5] == 1'b0 && diag.data[0] == 1'b0)
    else $error("slave set a master owned bit");
  valid_busy_a: assert property (diag.valid |-> diag_busy)
    else $error("byte offered while idle");
  rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=>
    axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read not answered next cycle");
  wr_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
    else $error("write response dropped early");
endmodule : dpd_diag_asserts

bind dpdiag_top dpd_diag_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .prm(prm), .cfg(cfg), .diag_req(diag_req), .diag_ready(diag_ready),
  .diag(diag), .diag_busy(diag_busy));

`default_nettype wire

// ### bench/dpd_master_model.sv
/*
 * Behavioural DP master: sends parameter and configuration telegrams and
 * drains the diagnostic stream. Assumes the bench calls its tasks after an edge.
 */
`timescale 1ns/1ps
`default_nettype none

module dpd_master_model (
  input  wire logic                  aclk,
  output var  dpdiag_pkg::dpd_prm_t  prm,
  output var  dpdiag_pkg::dpd_cfg_t  cfg,
  input  wire dpdiag_pkg::dpd_diag_t diag,
  output var  logic                  diag_ready
);
  logic [8:0]  rx[$];
  logic [7:0]  seen_st1;
  logic [15:0] seen_ident;
  logic        linked;

  initial
  begin
    prm = '0;
    cfg = '0;
    diag_ready = 1'b0;
    seen_st1 = 8'h00;
    seen_ident = 16'h0000;
    linked = 1'b0;
  end

  // Stall about one cycle in four so some bytes must be held
  always @(posedge aclk)
  begin
    if (diag.valid && diag_ready)
    begin
      if (rx.size() == 0) seen_st1 <= diag.data;
      if (rx.size() == 4) seen_ident[15:8] <= diag.data;
      if (rx.size() == 5) seen_ident[7:0] <= diag.data;
      if (diag.last) linked <= 1'b1;
      rx.push_back({diag.last, diag.data});
    end
    diag_ready <= ($urandom % 4) != 0;
  end

  // Ident as this master shows it: zero until the slave has answered once
  function automatic logic [15:0] view_ident();
    return linked ? seen_ident : 16'h0000;
  endfunction : view_ident

  // Status one as this master reports it; bits 7, 5 and 0 are its own
  function automatic logic [7:0] view_st1(input logic lock);
    logic bad;
    bad = linked && (seen_st1[7] || seen_st1[5] || seen_st1[0]);
    return {lock, seen_st1[6], bad, seen_st1[4:1], !linked};
  endfunction : view_st1

  task send_prm(input logic [7:0] m, input logic [15:0] id, input logic sy, input logic fr,
                input logic [7:0] len, input logic bad);
    @(posedge aclk);
    prm <= '{1'b1, m, id, sy, fr, len, bad};
    @(posedge aclk);
    // Payload flips once released, so stale fields are never trusted
    prm <= {1'b0, ~prm[$bits(prm)-2:0]};
  endtask : send_prm

  task send_cfg(input logic [31:0] c);
    @(posedge aclk);
    cfg <= '{1'b1, c};
    @(posedge aclk);
    cfg <= {1'b0, ~cfg.cfg};
  endtask : send_cfg
endmodule : dpd_master_model

`default_nettype wire

// ### bench/test_dp_slave_diag_status.sv
/*
 * Self-checking bench for the DP slave diagnostic block with a status model.
 * Assumes the master model drives telegrams and drains the response stream.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpdiag_regs.svh"

module test_dp_slave_diag_status;
  logic                      aclk;
  logic                      aresetn;
  logic                      diag_req;
  logic                      diag_ready;
  logic                      diag_busy;
  dpdiag_pkg::dpd_axil_req_t req;
  dpdiag_pkg::dpd_axil_rsp_t rsp;
  dpdiag_pkg::dpd_prm_t      prm;
  dpdiag_pkg::dpd_cfg_t      cfg;
  dpdiag_pkg::dpd_diag_t     diag;
  int                        err_total, num_checks, cyc, pf, ns, cf, pok, cok, ext;
  logic [31:0]               rd, cfgv, w;
  logic [1:0]                rs;
  logic [15:0]               idv;
  logic [7:0]                m, mf, st2, st3;

  dpdiag_top uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .prm(prm),
    .cfg(cfg), .diag_req(diag_req), .diag_ready(diag_ready), .diag(diag), .diag_busy(diag_busy));
  dpd_master_model mst (.aclk(aclk), .prm(prm), .cfg(cfg), .diag(diag), .diag_ready(diag_ready));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_total++;
      final_report();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task final_report;
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awaddr <= a; req.awvalid <= 1'b1; req.wdata <= d; req.wstrb <= 4'hf;
    req.wvalid <= 1'b1; req.bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    rs = rsp.bresp;
    req.bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [11:0] a);
    @(posedge aclk);
    req.araddr <= a; req.arvalid <= 1'b1; req.rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask : axi_rd

  function logic [7:0] st1f();
    return {1'b0, pf[0], 1'b0, ns[0], ext > 0, cf[0], !(pok && cok), 1'b0};
  endfunction : st1f

  function logic [7:0] mfield();
    return (pok && cok) ? mf : 8'hff;
  endfunction : mfield

  function logic [31:0] stat();
    return {8'h00, 8'(6 + ext), mfield(), st1f()};
  endfunction : stat

  // Second request lands mid-stream and must be ignored
  task run_diag;
    logic [7:0] h[6];
    int         n;
    h = '{st1f(), st2, st3, mfield(), idv[15:8], idv[7:0]};
    n = 6 + ext;
    mst.rx.delete();
    @(posedge aclk); diag_req <= 1'b1;
    @(posedge aclk); diag_req <= 1'b0;
    repeat (2) @(posedge aclk);
    diag_req <= 1'b1;
    @(posedge aclk); diag_req <= 1'b0;
    while (diag_busy !== 1'b0) @(posedge aclk);
    repeat (2) @(posedge aclk);
    chk(mst.rx.size(), n);
    for (int i = 0; i < n; i++)
      chk(mst.rx[i], {i == n - 1, (i < 6) ? h[i] : w[8*(i-6)+:8]});
  endtask : run_diag

  initial
  begin
    req = '0; aresetn = 1'b0; diag_req = 1'b0; cyc = 0; err_total = 0; num_checks = 0;
    pf = 0; ns = 0; cf = 0; pok = 0; cok = 0; ext = 0; mf = 8'h00; st2 = 8'h00; st3 = 8'h00;
    idv = 16'h5a5a; w = 32'h0;
    void'($urandom(8748));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(12'(`DPD_OFF_STATUS));
    chk(rd, stat());
    axi_rd(12'h010);
    chk(rs, 2'h3);
    chk(mst.view_st1(1'b0), 8'h01);
    chk(mst.view_ident(), 16'h0000);
    run_diag();
    chk(mst.view_ident(), idv);
    chk(mst.view_st1(1'b1), 8'h82);
    idv = 16'($urandom); cfgv = $urandom;
    axi_wr(12'(`DPD_OFF_IDENT), {16'h0000, idv});
    axi_wr(12'(`DPD_OFF_CFG), cfgv);
    axi_rd(12'(`DPD_OFF_IDENT));
    chk(rd, {16'h0000, idv});
    axi_rd(12'(`DPD_OFF_CFG));
    chk(rd, cfgv);
    axi_wr(12'h010, 32'h0);
    chk(rs, 2'h3);
    // Cases: short, bad value, wrong ident, sync, freeze, cfg mismatch, good
    for (int k = 0; k < 7; k++)
    begin
      m = 8'($urandom % 126);
      mst.send_prm(m, (k == 2) ? ~idv : idv, k == 3, k == 4, (k == 0) ? 8'h06 : 8'h08, k == 1);
      pf = (k < 3); ns = (k == 3 || k == 4); pok = (k > 4); mf = m;
      mst.send_cfg((k == 5) ? ~cfgv : cfgv);
      cf = (k == 5); cok = (k != 5);
      axi_rd(12'(`DPD_OFF_STATUS));
      chk(rd, stat());
    end
    st2 = 8'($urandom); st3 = 8'($urandom); w = $urandom; ext = 3;
    axi_wr(12'(`DPD_OFF_DIAGCTL), {8'h00, st3, st2, 8'h03});
    axi_wr(`DPD_OFF_EXT_BASE, w);
    axi_rd(12'(`DPD_OFF_STATUS));
    chk(rd, stat());
    run_diag();
    final_report();
  end
endmodule : test_dp_slave_diag_status

`default_nettype wire
